// [dpac_top.sv]
// Auxiliary control register with dual external data pointer.
// Assumes the core drives synchronous single-cycle SFR strobes.
// Function
// RQ1 - Two independent 16-bit pointers exist, one active at a time.
// RQ2 - Bit 0 selects pointer zero when clear and pointer one when set.
// RQ3 - Bit 2 always reads zero and ignores writes.
// RQ4 - Incrementing the register toggles only the select bit.
// RQ5 - Bit 5 maps boot flash at F800h to 0FFFFh when set.
// RQ6 - Bit 3 is a user flag with no hardware effect.
// RQ7 - Software never sets reserved bits 7, 6, 4 and 1.
// RQ8 - Reset clears select, bit 2 zero, boot bit from boot config.
// RQ9 - Register sits at address 0A2h, byte access only.
// RQ10 - Pointer operations touch only the selected pointer.
`timescale 1ns/10ps
`include "dpac_params.svh"
module dpac_top (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire dpac_pkg::dpac_sfr_s SFR_IN,
    input wire dpac_pkg::dpac_ptr_cmd_s PTR_CMD_IN,
    input wire logic BOOT_JUMP_CONFIG_BIT_IN,
    input wire logic [15:0] CODE_ADDR_IN,
    output logic [7:0] SFR_RDATA_OUT,
    output logic SFR_HIT_OUT,
    output logic [15:0] EXT_DATA_PTR_OUT,
    output logic POINTER_SELECT_BIT_OUT,
    output logic BOOT_FLASH_MAP_ENABLE_OUT,
    output logic BOOT_FLASH_HIT_OUT
);
    dpac_pkg::dpac_ctl_s s_q;
    dpac_pkg::dpac_ctl_s s_d;
    logic hit;
    logic [7:0] img;
    logic [15:0] p0;
    logic [15:0] p1;
    logic sel_move;

    // ==========================================================
    // Address decode, byte-wide only
    assign hit = (SFR_IN.addr == `DPAC_AUX_ADDR); // RQ9
    // Select bit may move at this edge
    assign sel_move = hit && (SFR_IN.wr || SFR_IN.inc);

    // Register image; reserved bits read zero
    always_comb begin
        img = 8'h00;
        img[`DPAC_BIT_SEL] = s_q.sel;
        img[`DPAC_BIT_FLAG] = s_q.flag;
        img[`DPAC_BIT_BOOT] = s_q.boot;
        img[`DPAC_BIT_ZERO] = 1'b0; // RQ3
    end

    // ==========================================================
    // Next state of the control register
    always_comb begin
        s_d = s_q;
        s_d.rdata = (hit && SFR_IN.rd) ? img : 8'h00;
        // Boot bit caught from config after reset release
        if (!s_q.boot_loaded) begin
            s_d.boot = BOOT_JUMP_CONFIG_BIT_IN; // RQ8
            s_d.boot_loaded = 1'b1;
        end
        if (hit && SFR_IN.wr) begin
            // Reserved and zero bits dropped; only the select, flag and boot bits are copied
            s_d.sel = SFR_IN.wdata[`DPAC_BIT_SEL]; // RQ2
            s_d.flag = SFR_IN.wdata[`DPAC_BIT_FLAG]; // RQ6
            s_d.boot = SFR_IN.wdata[`DPAC_BIT_BOOT]; // RQ5
            s_d.boot_loaded = 1'b1;
        end else if (hit && SFR_IN.inc) begin
            // Bit 2 stuck zero, so carry stops at bit 1
            s_d.sel = ~s_q.sel; // RQ4
        end
    end

    // Control register storage
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            s_q <= '{sel: 1'b0, flag: 1'b0, boot: 1'b0,
                     boot_loaded: 1'b0, rdata: 8'h00}; // RQ8
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Pointer bank
    dpac_ptr_bank u_bank (
        .clk_in(CLK_SYS_IN),
        .rst_in(RST_IN),
        .sel_in(s_q.sel),
        .cmd_in(PTR_CMD_IN),
        .ptr0_out(p0),
        .ptr1_out(p1)
    );

    // Outputs
    assign EXT_DATA_PTR_OUT = s_q.sel ? p1 : p0; // RQ1
    assign SFR_RDATA_OUT = s_q.rdata;
    assign SFR_HIT_OUT = hit;
    assign POINTER_SELECT_BIT_OUT = s_q.sel;
    assign BOOT_FLASH_MAP_ENABLE_OUT = s_q.boot;
    assign BOOT_FLASH_HIT_OUT = s_q.boot &&
        (CODE_ADDR_IN >= `DPAC_BOOT_LO); // RQ5

    // ==========================================================
    // Checks
    property p_zero_bit;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        (hit && SFR_IN.rd) |=> SFR_RDATA_OUT[2] == 1'b0;
    endproperty
    a_zero_bit: assert property (p_zero_bit) // RQ3
        else $error("Bit 2 read non-zero");
    property p_inc_toggle;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        (hit && SFR_IN.inc && !SFR_IN.wr && s_q.boot_loaded)
        |=> s_q.sel != $past(s_q.sel) && $stable(s_q.flag)
            && $stable(s_q.boot);
    endproperty
    a_inc_toggle: assert property (p_inc_toggle) // RQ4
        else $error("Increment did not toggle select only");
    property p_write_sel;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        (hit && SFR_IN.wr) |=> POINTER_SELECT_BIT_OUT ==
            $past(SFR_IN.wdata[0]);
    endproperty
    a_write_sel: assert property (p_write_sel) // RQ2
        else $error("Select bit not written");
    property p_write_flag;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        (hit && SFR_IN.wr) |=> s_q.flag == $past(SFR_IN.wdata[3]);
    endproperty
    a_write_flag: assert property (p_write_flag) // RQ6
        else $error("User flag not written");
    property p_boot_map;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        BOOT_FLASH_HIT_OUT == (BOOT_FLASH_MAP_ENABLE_OUT &&
            CODE_ADDR_IN[15:11] == 5'h1f);
    endproperty
    a_boot_map: assert property (p_boot_map) // RQ5
        else $error("Boot window mismatch");
    property p_boot_load;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        (!RST_IN && !s_q.boot_loaded && !(hit && SFR_IN.wr))
        |=> s_q.boot == $past(BOOT_JUMP_CONFIG_BIT_IN);
    endproperty
    a_boot_load: assert property (p_boot_load) // RQ8
        else $error("Boot bit not loaded from config");
    property p_ptr_sel;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        (PTR_CMD_IN.op == dpac_pkg::DPAC_OP_LD16 && !sel_move)
        |=> EXT_DATA_PTR_OUT == $past(PTR_CMD_IN.data);
    endproperty
    a_ptr_sel: assert property (p_ptr_sel) // RQ1
        else $error("Wrong pointer presented");
    property p_no_hit;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        (!hit && s_q.boot_loaded) |=> $stable(s_q.sel);
    endproperty
    a_no_hit: assert property (p_no_hit) // RQ9
        else $error("Select changed on other address");
    property p_rd_zero;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        !(hit && SFR_IN.rd) |=> SFR_RDATA_OUT == 8'h00;
    endproperty
    a_rd_zero: assert property (p_rd_zero) // RQ9
        else $error("Read data without access");
    // Read returns the register image, reserved bits zero
    property p_rd_image;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        (hit && SFR_IN.rd) |=> SFR_RDATA_OUT == {2'b00,
            $past(s_q.boot), 1'b0, $past(s_q.flag), 2'b00,
            $past(s_q.sel)};
    endproperty
    a_rd_image: assert property (p_rd_image) // RQ9
        else $error("Read image wrong");
    // Boot map bit follows a write
    property p_write_boot;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        (hit && SFR_IN.wr) |=> BOOT_FLASH_MAP_ENABLE_OUT ==
            $past(SFR_IN.wdata[5]);
    endproperty
    a_write_boot: assert property (p_write_boot) // RQ5
        else $error("Boot map bit not written");
    // Other addresses leave flag and boot bit alone
    property p_other_hold;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        (!hit && s_q.boot_loaded) |=> $stable(s_q.flag)
            && $stable(s_q.boot);
    endproperty
    a_other_hold: assert property (p_other_hold) // RQ9
        else $error("Flag or boot bit changed on other address");
    // Increment moves the presented pointer by one
    property p_ptr_inc;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        (PTR_CMD_IN.op == dpac_pkg::DPAC_OP_INC && !sel_move)
        |=> EXT_DATA_PTR_OUT == $past(EXT_DATA_PTR_OUT) + 16'h0001;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) // RQ10
        else $error("Presented pointer increment wrong");
    // High byte load keeps the low byte
    property p_ptr_ldhi;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        (PTR_CMD_IN.op == dpac_pkg::DPAC_OP_LDHI && !sel_move)
        |=> EXT_DATA_PTR_OUT == {$past(PTR_CMD_IN.data[7:0]),
            $past(EXT_DATA_PTR_OUT[7:0])};
    endproperty
    a_ptr_ldhi: assert property (p_ptr_ldhi) // RQ1
        else $error("High byte load wrong");
    // Low byte load keeps the high byte
    property p_ptr_ldlo;
        @(posedge CLK_SYS_IN) disable iff (RST_IN)
        (PTR_CMD_IN.op == dpac_pkg::DPAC_OP_LDLO && !sel_move)
        |=> EXT_DATA_PTR_OUT == {$past(EXT_DATA_PTR_OUT[15:8]),
            $past(PTR_CMD_IN.data[7:0])};
    endproperty
    a_ptr_ldlo: assert property (p_ptr_ldlo) // RQ1
        else $error("Low byte load wrong");

    // Main scenarios
    c_inc: cover property (@(posedge CLK_SYS_IN) hit && SFR_IN.inc);
    c_wr: cover property (@(posedge CLK_SYS_IN) hit && SFR_IN.wr);
    c_boot: cover property (@(posedge CLK_SYS_IN) BOOT_FLASH_HIT_OUT);
    c_wr_inc: cover property (@(posedge CLK_SYS_IN)
        hit && SFR_IN.wr && SFR_IN.inc);
    c_ptr_inc: cover property (@(posedge CLK_SYS_IN)
        PTR_CMD_IN.op == dpac_pkg::DPAC_OP_INC);
endmodule

// [dpac_params.svh]
// Constants for the dual pointer auxiliary control block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef DPAC_PARAMS_SVH
`define DPAC_PARAMS_SVH
// ==========================================================
// Register address and field positions
`define DPAC_AUX_ADDR 8'ha2
`define DPAC_BIT_SEL 0
`define DPAC_BIT_ZERO 2
`define DPAC_BIT_FLAG 3
`define DPAC_BIT_BOOT 5
// Writable bit mask: select, flag, boot map
`define DPAC_WR_MASK 8'h29
// ==========================================================
// Boot flash window in code space
`define DPAC_BOOT_LO 16'hf800
`define DPAC_BOOT_HI 16'hffff
// Reset value of the pointers
`define DPAC_PTR_RST 16'h0000
`endif

// [dpac_pkg.sv]
// Types for the dual pointer auxiliary control block.
// Assumes dpac_params.svh sits in the same folder.
`include "dpac_params.svh"
package dpac_pkg;
    // Pointer operation requested by the core
    typedef enum logic [4:0] {
        DPAC_OP_NONE = 5'h01,
        DPAC_OP_LDHI = 5'h02,
        DPAC_OP_LDLO = 5'h04,
        DPAC_OP_LD16 = 5'h08,
        DPAC_OP_INC = 5'h10
    } dpac_op_e;
    // Special function register access from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic inc;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dpac_sfr_s;
    // Pointer command from the core
    typedef struct packed {
        dpac_op_e op;
        logic [15:0] data;
    } dpac_ptr_cmd_s;
    // State of the pointer bank
    typedef struct packed {
        logic [15:0] p0;
        logic [15:0] p1;
    } dpac_bank_s;
    // State of the control register
    typedef struct packed {
        logic sel;
        logic flag;
        logic boot;
        logic boot_loaded;
        logic [7:0] rdata;
    } dpac_ctl_s;
endpackage

// [dpac_ptr_bank.sv]
// Pair of 16-bit external data pointers with update logic.
// Assumes the selected index comes from the control register.
`timescale 1ns/10ps
`include "dpac_params.svh"
module dpac_ptr_bank (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sel_in,
    input wire dpac_pkg::dpac_ptr_cmd_s cmd_in,
    output logic [15:0] ptr0_out,
    output logic [15:0] ptr1_out
);
    dpac_pkg::dpac_bank_s s_q;
    dpac_pkg::dpac_bank_s s_d;
    logic [15:0] cur;
    logic [15:0] nxt;

    // ==========================================================
    // Next value of the active pointer
    always_comb begin
        cur = sel_in ? s_q.p1 : s_q.p0;
        case (cmd_in.op)
            dpac_pkg::DPAC_OP_LDHI: nxt = {cmd_in.data[7:0], cur[7:0]};
            dpac_pkg::DPAC_OP_LDLO: nxt = {cur[15:8], cmd_in.data[7:0]};
            dpac_pkg::DPAC_OP_LD16: nxt = cmd_in.data;
            dpac_pkg::DPAC_OP_INC: nxt = cur + 16'h0001;
            default: nxt = cur;
        endcase
        s_d = s_q;
        // Only the selected pointer moves
        if (sel_in) begin // RQ10
            s_d.p1 = nxt;
        end else begin
            s_d.p0 = nxt;
        end
    end

    // Pointer storage
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= '{p0: `DPAC_PTR_RST, p1: `DPAC_PTR_RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign ptr0_out = s_q.p0;
    assign ptr1_out = s_q.p1;

    // ==========================================================
    // Checks
    property p_unsel_hold;
        @(posedge clk_in) disable iff (rst_in)
        sel_in |=> $stable(s_q.p0) or $past(rst_in);
    endproperty
    a_unsel_hold: assert property (p_unsel_hold) // RQ10
        else $error("Unselected pointer zero changed");
    property p_inc_one;
        @(posedge clk_in) disable iff (rst_in)
        (cmd_in.op == dpac_pkg::DPAC_OP_INC && sel_in)
        |=> s_q.p1 == $past(s_q.p1) + 16'h0001;
    endproperty
    a_inc_one: assert property (p_inc_one) // RQ1
        else $error("Pointer one increment wrong");
endmodule

// [dpac_core_model.sv]
// Core model: issues SFR accesses and pointer commands.
// Assumes one clock; the bench calls its tasks in turn.
`timescale 1ns/10ps
module dpac_core_model (
    input wire logic clk_in,
    output dpac_pkg::dpac_sfr_s sfr_out,
    output dpac_pkg::dpac_ptr_cmd_s cmd_out
);
    // ==========================================================
    // Idle values at time zero
    initial begin
        sfr_out = '0;
        cmd_out = '{dpac_pkg::DPAC_OP_NONE, 16'h0000};
    end
    // One-cycle SFR strobe; reserved bits never written as ones
    task automatic sfr(input logic [2:0] k, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clk_in);
        sfr_out <= '{k[2], k[1], k[0], a, d & 8'h2d};
        @(posedge clk_in);
        sfr_out <= '0;
    endtask
    // One-cycle pointer command
    task automatic ptr(input dpac_pkg::dpac_op_e op, input logic [15:0] d);
        @(posedge clk_in);
        cmd_out <= '{op, d};
        @(posedge clk_in);
        cmd_out <= '{dpac_pkg::DPAC_OP_NONE, ~d};
    endtask
endmodule

// [dual_pointer_aux_control_tb.sv]
// Self-checking bench for the dual pointer control block.
// Assumes dpac_pkg, dpac_top and dpac_core_model are compiled first.
`timescale 1ns/10ps
module dual_pointer_aux_control_tb;
    logic clk;
    logic rst = 1'b1;
    logic cfg = 1'b1;
    logic [15:0] caddr = 16'h0000;
    dpac_pkg::dpac_sfr_s sfr;
    dpac_pkg::dpac_ptr_cmd_s cmd;
    logic [7:0] rdata;
    logic [15:0] ptr;
    logic sel_o, boot_o, hit_o, sfr_hit;
    int n_fail = 0, samples_checked = 0, seed_v;
    int m_sel, m_flag, m_boot;
    logic [15:0] m_p [2];
    logic [7:0] d;
    dpac_pkg::dpac_op_e ops [4] = '{dpac_pkg::DPAC_OP_LDHI,
        dpac_pkg::DPAC_OP_LDLO, dpac_pkg::DPAC_OP_LD16,
        dpac_pkg::DPAC_OP_INC};
    // ==========================================================
    // Design, core model, clock
    dpac_top i_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .SFR_IN(sfr),
        .PTR_CMD_IN(cmd), .BOOT_JUMP_CONFIG_BIT_IN(cfg),
        .CODE_ADDR_IN(caddr), .SFR_RDATA_OUT(rdata),
        .SFR_HIT_OUT(sfr_hit),
        .EXT_DATA_PTR_OUT(ptr), .POINTER_SELECT_BIT_OUT(sel_o),
        .BOOT_FLASH_MAP_ENABLE_OUT(boot_o), .BOOT_FLASH_HIT_OUT(hit_o));
    dpac_core_model i_core (.clk_in(clk), .sfr_out(sfr), .cmd_out(cmd));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ==========================================================
    // Compare, reset, register and pointer helpers
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic do_reset(input logic c);
        cfg <= c;
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        m_sel = 0;
        m_flag = 0;
        m_boot = c;
        m_p = '{16'h0000, 16'h0000};
    endtask
    task automatic look();
        i_core.sfr(3'b010, 8'ha2, 8'h00);
        #1;
        chk("rdata", 16'(m_boot * 32 + m_flag * 8 + m_sel),
            16'(rdata & 8'h2d));
        chk("select", 16'(m_sel), 16'(sel_o));
        chk("boot", 16'(m_boot), 16'(boot_o));
        chk("pointer", m_p[m_sel], ptr);
    endtask
    task automatic wr(input logic [7:0] v);
        i_core.sfr(3'b100, 8'ha2, v);
        m_sel = v[0];
        m_flag = v[3];
        m_boot = v[5];
    endtask
    task automatic pc(input dpac_pkg::dpac_op_e op, input logic [15:0] v);
        i_core.ptr(op, v);
        case (op)
            dpac_pkg::DPAC_OP_LDHI: m_p[m_sel][15:8] = v[7:0];
            dpac_pkg::DPAC_OP_LDLO: m_p[m_sel][7:0] = v[7:0];
            dpac_pkg::DPAC_OP_LD16: m_p[m_sel] = v;
            default: m_p[m_sel] = m_p[m_sel] + 16'h0001;
        endcase
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report();
    end
    // Address decode checked at every falling edge out of reset
    always @(negedge clk) begin
        if (!rst) begin
            chk("sfr hit", 16'(sfr.addr == 8'ha2), 16'(sfr_hit));
        end
    end
    // Main sequence
    initial begin
        seed_v = $urandom(32'h9faa44bb);
        do_reset(1'b1);
        look();
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            d = (i == 0) ? 8'hff : 8'($urandom);
            wr(d);
            look();
            i_core.sfr(3'b100, 8'($urandom_range(8'ha3, 8'hff)), ~d);
            look();
        end
        $display("test write done");
        repeat (3) begin
            i_core.sfr(3'b001, 8'ha2, 8'h00);
            m_sel = 1 - m_sel;
            look();
        end
        // Write beats increment in the same cycle
        i_core.sfr(3'b101, 8'ha2, 8'h09);
        m_sel = 1;
        m_flag = 1;
        m_boot = 0;
        look();
        $display("test toggle done");
        for (int i = 0; i < 24; i++) begin
            if (i % 3 == 0) begin
                i_core.sfr(3'b001, 8'ha2, 8'h00);
                m_sel = 1 - m_sel;
            end
            pc(ops[i % 4], 16'($urandom));
            look();
        end
        pc(dpac_pkg::DPAC_OP_LD16, 16'hffff);
        pc(dpac_pkg::DPAC_OP_INC, 16'h0000);
        look();
        $display("test pointer done");
        for (int b = 0; b < 2; b++) begin
            wr(b ? 8'h20 : 8'h00);
            foreach (ops[j]) begin
                @(posedge clk);
                caddr <= 16'hf7ff + 16'(j * j * 2048 - j * 2047);
                @(posedge clk);
                #1;
                chk("boot hit", 16'(b && caddr >= 16'hf800),
                    16'(hit_o));
            end
        end
        $display("test boot map done");
        do_reset(1'b0);
        look();
        $display("test second reset done");
        final_report();
    end
endmodule
